/* common/cma_pkg.sv */
// package: constants and types of the core addressing block
package cma_pkg;
    // ==================================================
    // widths and map geometry
    localparam int unsigned AVS_AW      = 10;
    localparam int unsigned GPR_BYTES   = 80;
    localparam logic [4:0]  STK_FULL    = 5'h10;
    localparam int unsigned FSR_PM_BIT  = 15;
    // ==================================================
    // core register offsets inside every bank
    localparam logic [6:0] OFS_INDF0  = 7'h00;
    localparam logic [6:0] OFS_INDF1  = 7'h01;
    localparam logic [6:0] OFS_PCL    = 7'h02;
    localparam logic [6:0] OFS_STATUS = 7'h03;
    localparam logic [6:0] OFS_FSR0L  = 7'h04;
    localparam logic [6:0] OFS_FSR0H  = 7'h05;
    localparam logic [6:0] OFS_FSR1L  = 7'h06;
    localparam logic [6:0] OFS_FSR1H  = 7'h07;
    localparam logic [6:0] OFS_BSR    = 7'h08;
    localparam logic [6:0] OFS_WORKING_REGISTER   = 7'h09;
    localparam logic [6:0] OFS_PC_LATCH_HIGH = 7'h0A;
    localparam logic [6:0] OFS_INTERRUPT_CONTROL_REG = 7'h0B;
    localparam logic [6:0] OFS_GPR_LO = 7'h20;
    localparam logic [6:0] OFS_COM_LO = 7'h70;
    // ==================================================
    // bus map, byte addresses
    localparam logic [9:0] ADR_CMD  = 10'h200;
    localparam logic [9:0] ADR_PC   = 10'h204;
    localparam logic [9:0] ADR_POWER_CONTROL_REG = 10'h208;
    localparam logic [9:0] ADR_CTRL = 10'h20C;
    localparam logic [9:0] ADR_STK  = 10'h210;
    // ==================================================
    // bit positions and reset values
    localparam int unsigned SB_TO     = 4;
    localparam int unsigned SB_PD     = 3;
    localparam int unsigned SB_Z      = 2;
    localparam int unsigned SB_DC     = 1;
    localparam int unsigned SB_C      = 0;
    localparam int unsigned POWER_CONTROL_REG_OVF  = 7;
    localparam int unsigned POWER_CONTROL_REG_UNF  = 6;
    localparam int unsigned INTERRUPT_CONTROL_REG_GE = 7;
    localparam logic [4:0]  STATUS_RST = 5'h18;
    localparam logic [14:0] RESET_VEC  = 15'h0000;
    localparam logic [14:0] INT_VEC    = 15'h0004;
    // ==================================================
    // command word: op [3:0], f [10:4], dest [11], k [19:12]
    typedef enum logic [3:0] {
        OP_NOP = 4'h0, OP_ADDWF = 4'h1, OP_SUBWF = 4'h2, OP_MOVE_INDIRECT_TO_W = 4'h3,
        OP_MOVWI = 4'h4, OP_CALL = 4'h5, OP_RETURN = 4'h6, OP_INT = 4'h7,
        OP_RETFIE = 4'h8, OP_CLRWDT = 4'h9, OP_SLEEP = 4'hA, OP_WDTTO = 4'hB,
        OP_STEP = 4'hC
    } cma_op_t;
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001, ST_EXEC = 4'b0010, ST_PMW = 4'b0100, ST_ACK = 4'b1000
    } cma_state_t;
    typedef struct packed {
        logic [9:0]  address;
        logic        read;
        logic        write;
        logic [31:0] writedata;
    } cma_avs_req_t;
    typedef struct packed {
        logic [31:0] readdata;
        logic        waitrequest;
    } cma_avs_rsp_t;
endpackage

/* verilog/cma_core.sv */
// core addressing, stack, pointers and status logic
// How it works
// - sixteen-entry stack of fifteen-bit addresses
// - stack over/underflow flags, optional soft reset
// - two sixteen-bit pointers reach all memory
// - pointer high bit seven selects program memory
// - program read loads low eight bits
// - indirect writes never touch program memory
// - program memory access costs one extra cycle
// - fifteen-bit program counter
// - program addresses above implemented memory wrap around
// - reset vector zero, interrupt vector four
// - thirty-two banks of 128 bytes
// - core, special, general and common regions
// - direct accesses use bank select register
// - unimplemented locations read zero
// - twelve-bit data address, upper part bank
// - twelve core registers in every bank
// - arithmetic flags win over status writes
// - timeout and powerdown flags ignore writes
// - subtraction carries are inverted borrows
// - interrupt entry shadows and restores context
// - timeout flag set by clear/sleep, cleared by timeout
// - digit carry from fourth result bit
//
// The Avalon-MM slave port and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none
module cma_core
    import cma_pkg::*;
#(
    parameter int unsigned IMPL_BANKS = 2,
    parameter int unsigned PM_AW      = 14
) (
    input  wire logic             ref_clk,
    input  wire logic             nrst,
    input  wire cma_avs_req_t     avs_req,
    output var  cma_avs_rsp_t     avs_rsp,
    output var  logic [PM_AW-1:0] pm_addr,
    input  wire logic [13:0]      pm_rdata,
    output var  logic [14:0]      pc_out,
    output var  logic             soft_reset_pulse
);
    if (IMPL_BANKS < 1 || IMPL_BANKS > 32 || PM_AW < 1 || PM_AW > 15) begin : g_chk
        $error("cma_core: unsupported parameter values");
    end

    // ==================================================
    // state
    logic [7:0]  gpr_ff [IMPL_BANKS*GPR_BYTES];
    logic [7:0]  com_ff [16];
    logic [15:0] fsr_ff [2];
    logic [15:0] sh_fsr_ff [2];
    logic [14:0] stk_ff [16];
    logic [14:0] pc_ff;
    logic [4:0]  sp_ff;
    logic [4:0]  status_ff;
    logic [7:0]  w_ff;
    logic [4:0]  bsr_ff;
    logic [6:0]  pc_latch_high_ff;
    logic [7:0]  interrupt_control_reg_ff;
    logic [7:0]  sh_w_ff;
    logic [2:0]  sh_st_ff;
    logic [4:0]  sh_bsr_ff;
    logic [6:0]  sh_pc_latch_high_ff;
    logic        ovf_ff;
    logic        unf_ff;
    logic        rst_en_ff;
    logic        soft_ff;
    cma_state_t  st_ff;
    cma_state_t  nxt_st;
    logic [31:0] wd_ff;
    logic        cmd_ff;
    logic [7:0]  rdata_ff;
    logic [PM_AW-1:0] pm_addr_ff;

    // ==================================================
    // helpers
    function automatic int gidx(input logic [4:0] b, input logic [6:0] o);
        gidx = int'(b) * GPR_BYTES + int'(o) - int'(OFS_GPR_LO);
    endfunction

    function automatic logic [14:0] pc_inc(input logic [14:0] p);
        logic [PM_AW-1:0] q;
        q = p[PM_AW-1:0] + 1'b1;
        pc_inc = 15'(q);
    endfunction

    function automatic logic [7:0] dm_rd(input logic [11:0] a);
        logic [6:0] o;
        logic [4:0] b;
        o = a[6:0];
        b = a[11:7];
        dm_rd = 8'h00;
        if (o == OFS_PCL) dm_rd = pc_ff[7:0];
        else if (o == OFS_STATUS) dm_rd = {3'h0, status_ff};
        else if (o == OFS_FSR0L) dm_rd = fsr_ff[0][7:0];
        else if (o == OFS_FSR0H) dm_rd = fsr_ff[0][15:8];
        else if (o == OFS_FSR1L) dm_rd = fsr_ff[1][7:0];
        else if (o == OFS_FSR1H) dm_rd = fsr_ff[1][15:8];
        else if (o == OFS_BSR) dm_rd = {3'h0, bsr_ff};
        else if (o == OFS_WORKING_REGISTER) dm_rd = w_ff;
        else if (o == OFS_PC_LATCH_HIGH) dm_rd = {1'b0, pc_latch_high_ff};
        else if (o == OFS_INTERRUPT_CONTROL_REG) dm_rd = interrupt_control_reg_ff;
        // only implemented banks hold general ram
        else if (o >= OFS_GPR_LO && o < OFS_COM_LO && 32'(b) < IMPL_BANKS) dm_rd = gpr_ff[gidx(b, o)];
        else if (o >= OFS_COM_LO) dm_rd = com_ff[o[3:0]];
    endfunction

    // linear region not modelled, reads zero
    function automatic logic ind_ok(input logic n);
        ind_ok = fsr_ff[n][15:12] == 4'h0;
    endfunction

    // ==================================================
    // command decode
    logic [3:0]  cmd_op;
    logic [6:0]  cmd_f;
    logic        cmd_dest;
    logic [7:0]  cmd_k;
    logic        ksel;
    logic        need_pm;
    logic        commit;
    assign cmd_op   = wd_ff[3:0];
    assign cmd_f    = wd_ff[10:4];
    assign cmd_dest = wd_ff[11];
    assign cmd_k    = wd_ff[19:12];
    assign ksel     = cmd_k[0];
    // program memory read takes the extra state
    assign need_pm = cmd_op == OP_MOVE_INDIRECT_TO_W && fsr_ff[ksel][FSR_PM_BIT];
    assign commit  = (st_ff == ST_EXEC && !need_pm) || (st_ff == ST_PMW && cmd_ff);

    // ==================================================
    // bus decode
    logic [6:0] bus_ofs;
    logic       bus_req;
    logic       is_cmd;
    logic       bus_wr;
    logic       bus_pm_rd;
    logic [7:0] rd_v;
    assign bus_ofs = avs_req.address[8:2];
    assign bus_req = st_ff == ST_IDLE && (avs_req.read || avs_req.write);
    assign is_cmd  = avs_req.write && avs_req.address == ADR_CMD;
    assign bus_wr  = bus_req && avs_req.write && !is_cmd;
    assign bus_pm_rd = bus_req && avs_req.read && !avs_req.address[9]
                     && bus_ofs[6:1] == 6'h00 && fsr_ff[bus_ofs[0]][FSR_PM_BIT];

    always_comb begin
        rd_v = 8'h00;
        if (!avs_req.address[9]) begin
            if (bus_ofs[6:1] == 6'h00) rd_v = ind_ok(bus_ofs[0]) ? dm_rd(fsr_ff[bus_ofs[0]][11:0]) : 8'h00;
            else rd_v = dm_rd({bsr_ff, bus_ofs});
        end else if (avs_req.address == ADR_PC) rd_v = pc_ff[7:0];
        else if (avs_req.address == ADR_POWER_CONTROL_REG) rd_v = {ovf_ff, unf_ff, 6'h00};
        else if (avs_req.address == ADR_CTRL) rd_v = {7'h00, rst_en_ff};
        else if (avs_req.address == ADR_STK) rd_v = {3'h0, sp_ff};
    end

    // ==================================================
    // alu
    logic       sub;
    logic [7:0] fval;
    logic [7:0] bop;
    logic [8:0] sum9;
    logic [4:0] lo5;
    logic       flag_upd;
    logic [7:0] mov_v;
    assign sub  = cmd_op == OP_SUBWF;
    always_comb fval = dm_rd({bsr_ff, cmd_f});
    // subtract adds two's complement, carry means no borrow
    assign bop  = sub ? ~w_ff : w_ff;
    assign sum9 = {1'b0, fval} + {1'b0, bop} + {8'h00, sub};
    assign lo5  = {1'b0, fval[3:0]} + {1'b0, bop[3:0]} + {4'h0, sub};
    assign flag_upd = commit && (cmd_op == OP_ADDWF || cmd_op == OP_SUBWF);
    // low byte of the program word only
    always_comb mov_v = (st_ff == ST_PMW) ? pm_rdata[7:0] : (ind_ok(ksel) ? dm_rd(fsr_ff[ksel][11:0]) : 8'h00);

    // ==================================================
    // shared data memory write port
    logic        wr_en;
    logic [11:0] wr_a;
    logic [7:0]  wr_d;
    logic [6:0]  wr_o;
    logic [4:0]  wr_b;
    always_comb begin
        wr_en = 1'b0;
        wr_a  = 12'h000;
        wr_d  = 8'h00;
        if (bus_wr && !avs_req.address[9]) begin
            wr_d = avs_req.writedata[7:0];
            if (bus_ofs[6:1] == 6'h00) begin
                // program memory pointer drops the write
                wr_en = ind_ok(bus_ofs[0]);
                wr_a  = fsr_ff[bus_ofs[0]][11:0];
            end else begin
                wr_en = 1'b1;
                wr_a  = {bsr_ff, bus_ofs};
            end
        end else if (flag_upd && cmd_dest) begin
            wr_en = 1'b1;
            wr_a  = {bsr_ff, cmd_f};
            wr_d  = sum9[7:0];
        end else if (commit && cmd_op == OP_MOVWI) begin
            wr_en = ind_ok(ksel);
            wr_a  = fsr_ff[ksel][11:0];
            wr_d  = w_ff;
        end
    end
    assign wr_o = wr_a[6:0];
    assign wr_b = wr_a[11:7];

    // ==================================================
    // bus handshake fsm
    always_comb begin
        nxt_st = st_ff;
        case (st_ff)
            ST_IDLE: begin
                if (bus_req) nxt_st = is_cmd ? ST_EXEC : (bus_pm_rd ? ST_PMW : ST_ACK);
            end
            ST_EXEC: nxt_st = need_pm ? ST_PMW : ST_ACK;
            ST_PMW:  nxt_st = ST_ACK;
            ST_ACK:  nxt_st = ST_IDLE;
            default: nxt_st = ST_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            st_ff  <= ST_IDLE;
            wd_ff  <= 32'h0000_0000;
            cmd_ff <= 1'b0;
        end else begin
            st_ff <= nxt_st;
            if (bus_req) begin
                wd_ff  <= avs_req.writedata;
                cmd_ff <= is_cmd;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            rdata_ff   <= 8'h00;
            pm_addr_ff <= '0;
        end else begin
            if (bus_req && avs_req.read) rdata_ff <= rd_v;
            else if (st_ff == ST_PMW && !cmd_ff) rdata_ff <= pm_rdata[7:0];
            if (bus_pm_rd) pm_addr_ff <= fsr_ff[bus_ofs[0]][PM_AW-1:0];
            else if (st_ff == ST_EXEC && need_pm) pm_addr_ff <= fsr_ff[ksel][PM_AW-1:0];
        end
    end

    assign avs_rsp.readdata    = {24'h000000, rdata_ff};
    assign avs_rsp.waitrequest = st_ff != ST_ACK;
    assign pm_addr = pm_addr_ff;
    assign pc_out  = pc_ff;
    assign soft_reset_pulse = soft_ff;

    // ==================================================
    // stack and program counter
    logic push;
    logic pop;
    logic ovf_evt;
    logic unf_evt;
    logic soft_set;
    assign push = commit && (cmd_op == OP_CALL || cmd_op == OP_INT);
    assign pop  = commit && (cmd_op == OP_RETURN || cmd_op == OP_RETFIE);
    assign ovf_evt = push && sp_ff == STK_FULL;
    assign unf_evt = pop && sp_ff == 5'h00;
    assign soft_set = (ovf_evt || unf_evt) && rst_en_ff;

    // sixteen entries, full count blocks pushes
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            sp_ff <= 5'h00;
            for (int i = 0; i < 16; i++) stk_ff[i] <= 15'h0000;
        end else if (soft_set) begin
            sp_ff <= 5'h00;
        end else if (push && !ovf_evt) begin
            stk_ff[sp_ff[3:0]] <= (cmd_op == OP_INT) ? pc_ff : pc_inc(pc_ff);
            sp_ff <= sp_ff + 5'h01;
        end else if (pop && !unf_evt) begin
            sp_ff <= sp_ff - 5'h01;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) pc_ff <= RESET_VEC;
        else if (soft_set) pc_ff <= RESET_VEC;
        else if (wr_en && wr_o == OFS_PCL) pc_ff <= {pc_latch_high_ff, wr_d};
        else if (commit) begin
            case (cmd_op)
                OP_CALL:   pc_ff <= {pc_latch_high_ff, cmd_k};
                OP_INT:    pc_ff <= INT_VEC;
                OP_RETURN,
                OP_RETFIE: pc_ff <= unf_evt ? pc_inc(pc_ff) : stk_ff[sp_ff[3:0] - 4'h1];
                default:   pc_ff <= pc_inc(pc_ff);
            endcase
        end
    end

    // set wins over a clearing write
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            ovf_ff    <= 1'b0;
            unf_ff    <= 1'b0;
            rst_en_ff <= 1'b0;
            soft_ff   <= 1'b0;
        end else begin
            ovf_ff  <= ovf_evt | (ovf_ff & ~(bus_wr && avs_req.address == ADR_POWER_CONTROL_REG && !avs_req.writedata[POWER_CONTROL_REG_OVF]));
            unf_ff  <= unf_evt | (unf_ff & ~(bus_wr && avs_req.address == ADR_POWER_CONTROL_REG && !avs_req.writedata[POWER_CONTROL_REG_UNF]));
            soft_ff <= soft_set;
            if (bus_wr && avs_req.address == ADR_CTRL) rst_en_ff <= avs_req.writedata[0];
        end
    end

    // ==================================================
    // status register
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) status_ff <= STATUS_RST;
        else begin
            if (commit && cmd_op == OP_CLRWDT) status_ff[SB_TO:SB_PD] <= 2'b11;
            else if (commit && cmd_op == OP_SLEEP) status_ff[SB_TO:SB_PD] <= 2'b10;
            else if (commit && cmd_op == OP_WDTTO) status_ff[SB_TO] <= 1'b0;
            if (flag_upd) status_ff[SB_Z:SB_C] <= {sum9[7:0] == 8'h00, lo5[4], sum9[8]};
            else if (commit && cmd_op == OP_MOVE_INDIRECT_TO_W) status_ff[SB_Z] <= mov_v == 8'h00;
            else if (commit && cmd_op == OP_RETFIE) status_ff[SB_Z:SB_C] <= sh_st_ff;
            else if (wr_en && wr_o == OFS_STATUS) status_ff[SB_Z:SB_C] <= wr_d[SB_Z:SB_C];
        end
    end

    // ==================================================
    // core registers and shadows
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) w_ff <= 8'h00;
        else if (commit && cmd_op == OP_MOVE_INDIRECT_TO_W) w_ff <= mov_v;
        else if (flag_upd && !cmd_dest) w_ff <= sum9[7:0];
        else if (commit && cmd_op == OP_RETFIE) w_ff <= sh_w_ff;
        else if (wr_en && wr_o == OFS_WORKING_REGISTER) w_ff <= wr_d;
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            bsr_ff    <= 5'h00;
            pc_latch_high_ff <= 7'h00;
            interrupt_control_reg_ff <= 8'h00;
            fsr_ff[0] <= 16'h0000;
            fsr_ff[1] <= 16'h0000;
        end else if (commit && cmd_op == OP_RETFIE) begin
            bsr_ff    <= sh_bsr_ff;
            pc_latch_high_ff <= sh_pc_latch_high_ff;
            fsr_ff    <= sh_fsr_ff;
            interrupt_control_reg_ff[INTERRUPT_CONTROL_REG_GE] <= 1'b1;
        end else if (commit && cmd_op == OP_INT) begin
            interrupt_control_reg_ff[INTERRUPT_CONTROL_REG_GE] <= 1'b0;
        end else if (wr_en) begin
            if (wr_o == OFS_BSR) bsr_ff <= wr_d[4:0];
            else if (wr_o == OFS_PC_LATCH_HIGH) pc_latch_high_ff <= wr_d[6:0];
            else if (wr_o == OFS_INTERRUPT_CONTROL_REG) interrupt_control_reg_ff <= wr_d;
            else if (wr_o == OFS_FSR0L) fsr_ff[0][7:0] <= wr_d;
            else if (wr_o == OFS_FSR0H) fsr_ff[0][15:8] <= wr_d;
            else if (wr_o == OFS_FSR1L) fsr_ff[1][7:0] <= wr_d;
            else if (wr_o == OFS_FSR1H) fsr_ff[1][15:8] <= wr_d;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            sh_w_ff      <= 8'h00;
            sh_st_ff     <= 3'h0;
            sh_bsr_ff    <= 5'h00;
            sh_pc_latch_high_ff <= 7'h00;
            sh_fsr_ff[0] <= 16'h0000;
            sh_fsr_ff[1] <= 16'h0000;
        end else if (commit && cmd_op == OP_INT) begin
            sh_w_ff      <= w_ff;
            sh_st_ff     <= status_ff[SB_Z:SB_C];
            sh_bsr_ff    <= bsr_ff;
            sh_pc_latch_high_ff <= pc_latch_high_ff;
            sh_fsr_ff    <= fsr_ff;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < IMPL_BANKS * GPR_BYTES; i++) gpr_ff[i] <= 8'h00;
            for (int i = 0; i < 16; i++) com_ff[i] <= 8'h00;
        end else if (wr_en) begin
            if (wr_o >= OFS_GPR_LO && wr_o < OFS_COM_LO && 32'(wr_b) < IMPL_BANKS) gpr_ff[gidx(wr_b, wr_o)] <= wr_d;
            else if (wr_o >= OFS_COM_LO) com_ff[wr_o[3:0]] <= wr_d;
        end
    end

    // ==================================================
    // checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    stk_bound_a: assert property (sp_ff <= STK_FULL)
        else $error("stack count beyond sixteen");
    ovf_flag_a: assert property (ovf_evt |=> ovf_ff)
        else $error("overflow flag not set");
    soft_rst_a: assert property (soft_set |=> soft_reset_pulse && pc_ff == RESET_VEC && sp_ff == 5'h00)
        else $error("stack fault reset missing");
    pm_low_a: assert property (st_ff == ST_PMW && cmd_ff |=> w_ff == $past(pm_rdata[7:0]))
        else $error("program byte not loaded");
    pm_extra_a: assert property (st_ff == ST_EXEC && need_pm |=> st_ff == ST_PMW ##1 st_ff == ST_ACK)
        else $error("program access cycle wrong");
    pc_wrap_a: assert property (commit && cmd_op == OP_STEP && pc_ff[PM_AW-1:0] == '1 && !soft_set
        |=> pc_ff == RESET_VEC)
        else $error("program counter did not wrap");
    int_vec_a: assert property (commit && cmd_op == OP_INT && !soft_set |=> pc_ff == INT_VEC)
        else $error("interrupt vector wrong");
    to_pd_a: assert property (wr_en && wr_o == OFS_STATUS && !commit
        |=> $stable(status_ff[SB_TO:SB_PD]))
        else $error("timeout or powerdown written");
    flag_win_a: assert property (flag_upd && cmd_dest && cmd_f == OFS_STATUS
        |=> status_ff[SB_Z] == ($past(sum9[7:0]) == 8'h00))
        else $error("status write beat flags");
    shadow_a: assert property (commit && cmd_op == OP_RETFIE |=> w_ff == $past(sh_w_ff))
        else $error("working register not restored");
endmodule // cma_core
`default_nettype wire

/* bench/cma_core_tb.sv */
// self-checking bench of the core addressing block
`timescale 1ns/1ps
`default_nettype none
module cma_core_tb
    import cma_pkg::*;
;
    logic         ref_clk;
    logic         nrst;
    cma_avs_req_t req;
    cma_avs_rsp_t rsp;
    logic [13:0]  pm_addr;
    logic [13:0]  pm_rdata;
    logic [14:0]  pc_out;
    logic         soft_reset_pulse;
    logic         pulse_seen = 1'b0;
    logic [7:0]   rd;
    int           lat;
    int           cyc = 0;
    int           error_cnt;
    int           n_compared;
    // ==================================================
    // clock, reset, program memory stand-in
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end
    cma_core cma_core_inst (
        .ref_clk          (ref_clk),
        .nrst             (nrst),
        .avs_req          (req),
        .avs_rsp          (rsp),
        .pm_addr          (pm_addr),
        .pm_rdata         (pm_rdata),
        .pc_out           (pc_out),
        .soft_reset_pulse (soft_reset_pulse)
    );
    // asynchronous program memory, word differs from its address so a stale fetch shows
    always_comb pm_rdata = pm_addr ^ 14'h2AAA;
    // latched at once, so a check right after the answer edge sees it
    always @(posedge soft_reset_pulse) pulse_seen = 1'b1;
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt = error_cnt + 1;
            stop_test();
        end
    end
    // ==================================================
    // bus tasks and compare
    task automatic acc(input logic w, input logic [9:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge ref_clk);
        req.address   <= a;
        req.writedata <= d;
        req.write     <= w;
        req.read      <= ~w;
        // request stands until waitrequest is sampled low at a rising edge
        do begin
            @(posedge ref_clk);
            n = n + 1;
        end while (rsp.waitrequest !== 1'b0);
        rd  = rsp.readdata[7:0];
        lat = n - 1;
        req.write <= 1'b0;
        req.read  <= 1'b0;
    endtask
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_compared = n_compared + 1;
        if (got !== exp) begin
            error_cnt = error_cnt + 1;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic rchk(input string what, input logic [9:0] a, input logic [7:0] exp);
        acc(1'b0, a, 32'h0);
        chk(what, {8'h00, exp}, {8'h00, rd});
    endtask
    task automatic stop_test();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // ==================================================
    // scenarios
    logic [3:0] wop [3]  = '{4'hB, 4'hA, 4'h9};
    logic [7:0] wexp [3] = '{8'h0F, 8'h17, 8'h1F};
    initial begin
        nrst = 1'b0;
        req = '0;
        error_cnt = 0;
        n_compared = 0;
        repeat (8) @(posedge ref_clk);
        nrst <= 1'b1;
        chk("pc reset", 16'h0000, {1'b0, pc_out});
        rchk("status reset", 10'h00C, 8'h18);
        acc(1'b1, 10'h00C, 32'hFF);
        rchk("status write", 10'h00C, 8'h1F);
        acc(1'b1, 10'h024, 32'h0F);
        acc(1'b1, 10'h080, 32'h01);
        acc(1'b1, 10'h200, 32'hA01);
        rchk("add result", 10'h080, 8'h10);
        rchk("add flags", 10'h00C, 8'h1A);
        acc(1'b1, 10'h200, 32'hA02);
        rchk("sub result", 10'h080, 8'h01);
        rchk("sub flags", 10'h00C, 8'h19);
        // flags computed by the add win over the status destination
        acc(1'b1, 10'h024, 32'hE7);
        acc(1'b1, 10'h200, 32'h831);
        rchk("flag priority", 10'h00C, 8'h1F);
        for (int i = 0; i < 3; i++) begin
            acc(1'b1, 10'h200, {28'h0, wop[i]});
            rchk("wdt flags", 10'h00C, wexp[i]);
        end
        // pointer 0 to program memory, upper bits above 16K wrap
        acc(1'b1, 10'h010, 32'h34);
        acc(1'b1, 10'h014, 32'hD2);
        rchk("prog read", 10'h000, 8'h9E);
        chk("prog latency", 16'd2, lat[15:0]);
        chk("pm wrap", 16'h1234, {2'b00, pm_addr});
        acc(1'b1, 10'h000, 32'h55);
        rchk("prog no write", 10'h000, 8'h9E);
        acc(1'b1, 10'h200, 32'h3);
        rchk("move_indirect_to_w low byte", 10'h024, 8'h9E);
        acc(1'b1, 10'h018, 32'h20);
        acc(1'b1, 10'h01C, 32'h00);
        rchk("data pointer", 10'h004, 8'h01);
        chk("data latency", 16'd1, lat[15:0]);
        // banking
        acc(1'b1, 10'h020, 32'h01);
        acc(1'b1, 10'h080, 32'hA5);
        acc(1'b1, 10'h1C0, 32'h5A);
        acc(1'b1, 10'h020, 32'h00);
        rchk("bank0 ram", 10'h080, 8'h01);
        rchk("common ram", 10'h1C0, 8'h5A);
        acc(1'b1, 10'h020, 32'h01);
        rchk("bank1 ram", 10'h080, 8'hA5);
        acc(1'b1, 10'h020, 32'h05);
        rchk("absent bank", 10'h080, 8'h00);
        rchk("core reg bank5", 10'h020, 8'h05);
        rchk("unimpl offset", 10'h030, 8'h00);
        // stack: sixteen calls fit, the next overflows
        acc(1'b1, 10'h028, 32'h7F);
        for (int i = 0; i < 16; i++) acc(1'b1, 10'h200, 32'hFF005);
        chk("call target", 16'h7FFF, {1'b0, pc_out});
        acc(1'b1, 10'h200, 32'hC);
        chk("pc wrap", 16'h0000, {1'b0, pc_out});
        rchk("stack depth", 10'h210, 8'h10);
        rchk("no overflow", 10'h208, 8'h00);
        acc(1'b1, 10'h200, 32'hFF005);
        rchk("overflow", 10'h208, 8'h80);
        acc(1'b1, 10'h208, 32'h00);
        for (int i = 0; i < 16; i++) acc(1'b1, 10'h200, 32'h6);
        chk("return pc", 16'h0008, {1'b0, pc_out});
        rchk("no underflow", 10'h208, 8'h00);
        acc(1'b1, 10'h200, 32'h6);
        rchk("underflow", 10'h208, 8'h40);
        chk("no soft reset", 16'h0000, {15'h0, pulse_seen});
        acc(1'b1, 10'h20C, 32'h01);
        acc(1'b1, 10'h200, 32'h6);
        chk("soft reset", 16'h0001, {15'h0, pulse_seen});
        chk("soft reset pc", 16'h0000, {1'b0, pc_out});
        // interrupt entry and context restore
        acc(1'b1, 10'h024, 32'h33);
        acc(1'b1, 10'h200, 32'h7);
        chk("int vector", 16'h0004, {1'b0, pc_out});
        acc(1'b1, 10'h024, 32'h44);
        acc(1'b1, 10'h200, 32'h8);
        rchk("shadow w", 10'h024, 8'h33);
        stop_test();
    end
endmodule // cma_core_tb
`default_nettype wire
